// [logic/bsdi_boot_select.v]
// boot source capture, boot region alias and info registers on axi4-lite
//
// How it works
// - capture both pins on fourth clock edge
// - decode pins: flash, loader or sram
// - ignore pin changes after capture
// - alias flash or system memory at zero
// - sram kilobytes in density upper half
// - flash kilobytes in density lower half
// - 96-bit serial in three words
// - density and serial words read only
// - bit 7 reduces execution efficiency
`timescale 1ns/10ps
`default_nettype none
`include "bsdi_regs.vh"
module bsdi_boot_select #(
  parameter [15:0] SRAM_KB = 16'h0008,  // sram size in kilobytes
  parameter [15:0] FLASH_KB = 16'h0020, // flash size in kilobytes
  parameter [95:0] SERIAL = 96'h0123456789abcdef00112233 // arbitrary value
)
(
  input wire aclk,                   // system core clock
  input wire aresetn,                // synchronous reset, active low
  input wire boot_select_low_pin,    // boot pin, low bit
  input wire boot_select_high_pin,   // boot pin, high bit
  // register bus, axi4-lite slave
  input wire [31:0] s_axi_awaddr,    // write address
  input wire s_axi_awvalid,          // write address valid
  output reg s_axi_awready,          // write address ready
  input wire [31:0] s_axi_wdata,     // write data
  input wire [3:0] s_axi_wstrb,      // write byte strobes
  input wire s_axi_wvalid,           // write data valid
  output reg s_axi_wready,           // write data ready
  output reg [1:0] s_axi_bresp,      // write response
  output reg s_axi_bvalid,           // write response valid
  input wire s_axi_bready,           // write response ready
  input wire [31:0] s_axi_araddr,    // read address
  input wire s_axi_arvalid,          // read address valid
  output reg s_axi_arready,          // read address ready
  output reg [31:0] s_axi_rdata,     // read data
  output reg [1:0] s_axi_rresp,      // read response
  output reg s_axi_rvalid,           // read data valid
  input wire s_axi_rready,           // read data ready
  // boot outcome towards the core and the memory map
  output reg [1:0] boot_source,      // captured boot source
  output reg [31:0] boot_alias_base, // native base aliased at zero
  output reg boot_alias_enable,      // alias active (flash or sysmem)
  output reg core_fetch_enable,      // core may issue vector fetch
  output reg exec_speed_reduce       // reduced execution efficiency
);

  // pin synchronisers, two stages each
  reg [1:0] pin_meta;   // first stage, read only by second
  reg [1:0] pin_sync;   // second stage
  reg [2:0] edge_count; // edges since reset release
  reg captured;         // boot choice latched
  reg [1:0] next_source; // decoded source from synced pins
  // write side holding
  reg aw_held;          // address accepted
  reg w_held;           // data accepted
  reg [31:0] aw_addr;   // stored write address
  reg [31:0] w_data;    // stored write data
  reg [3:0] w_strb;     // stored strobes
  // read side
  reg rd_pending;       // read in flight, rom or local register
  reg [1:0] rd_kind;    // 0 rom, 1 tuning, 2 status, 3 unmapped
  reg [1:0] rom_index;  // rom word select
  reg rd_settle;        // rom word has had its edge to settle
  wire [31:0] rom_data; // rom registered output

  // pins cross into the clock domain through two flops
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // reset: both stages low
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end
    else
    begin
      // the first stage may go metastable; only the second reads it
      pin_meta <= {boot_select_high_pin, boot_select_low_pin};
      pin_sync <= pin_meta;
    end
  end

  // decode of the synced pin pair
  always @*
  begin
    // only used on the capture edge, so later pin use is harmless
    // pin decode table
    if (!pin_sync[0])
      next_source = `BSDI_SRC_FLASH; // high pin does not matter
    else if (!pin_sync[1])
      next_source = `BSDI_SRC_LOADER;
    else
      next_source = `BSDI_SRC_SRAM;
  end

  // counts edges after reset; the sync delay makes the fourth edge
  // see the pin level two edges earlier, a documented latency
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // reset: source and alias base at flash, alias off until the capture
      edge_count <= 3'h0;
      captured <= 1'b0;
      boot_source <= `BSDI_SRC_FLASH;
      boot_alias_base <= `BSDI_BASE_FLASH;
      boot_alias_enable <= 1'b0;
      core_fetch_enable <= 1'b0;
    end
    else
    begin
      // count and capture only until the choice is held
      // limitation: pins must hold steady from reset to capture
      if (!captured)
        edge_count <= edge_count + 3'h1;
      if (!captured && edge_count == `BSDI_CAPTURE_EDGE - 3'h1)
      begin
        captured <= 1'b1;
        boot_source <= next_source;
        case (next_source)
          `BSDI_SRC_FLASH:
          begin
            boot_alias_base <= `BSDI_BASE_FLASH;
            boot_alias_enable <= 1'b1;
          end
          `BSDI_SRC_LOADER:
          begin
            boot_alias_base <= `BSDI_BASE_SYSMEM;
            boot_alias_enable <= 1'b1;
          end
          default:
          begin
            // sram is not aliased; software moves the vector table
            boot_alias_base <= `BSDI_BASE_SRAM;
            boot_alias_enable <= 1'b0;
          end
        endcase
      end
      // release core one edge after mapping settles
      // first fetch from zero only once released
      // one edge of margin: the alias is settled before the first fetch
      if (captured)
        core_fetch_enable <= 1'b1;
    end
  end

  // write channel: take address and data in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // reset: bus idle, tuning bit at its reset value of zero
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BSDI_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      exec_speed_reduce <= 1'b0;
    end
    else
    begin
      // ready pulses one cycle to take a waiting item
      // readies stay low while a response waits: one write at a time
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid
        && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid
        && !s_axi_bvalid;
      // address and data may be taken in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // both taken: commit and respond
      // the response code says whether the word took the write
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr & 32'hfffffffc)
          `BSDI_OFS_TUNING:
          begin
            // other bits reserved, writes dropped
            // a write without byte 0 leaves the bit alone
            if (w_strb[0])
              exec_speed_reduce <= w_data[`BSDI_EXEC_REDUCE_BIT];
            s_axi_bresp <= `BSDI_RESP_OKAY;
          end
          `BSDI_OFS_DENSITY, `BSDI_OFS_SERIAL0, `BSDI_OFS_SERIAL1,
          `BSDI_OFS_SERIAL2, `BSDI_OFS_BOOTSTAT:
            s_axi_bresp <= `BSDI_RESP_SLVERR;
          default:
            s_axi_bresp <= `BSDI_RESP_DECERR;
        endcase
      end
      // the response stands until the master takes it
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read address decode into a rom index or a local register
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // reset: read side idle
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `BSDI_RESP_OKAY;
      rd_pending <= 1'b0;
      rd_settle <= 1'b0;
      rd_kind <= 2'h0;
      rom_index <= 2'h0;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !rd_pending
        && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        rd_pending <= 1'b1;
        case (s_axi_araddr & 32'hfffffffc)
          `BSDI_OFS_DENSITY: begin rd_kind <= 2'h0; rom_index <= 2'h0; end
          `BSDI_OFS_SERIAL0: begin rd_kind <= 2'h0; rom_index <= 2'h1; end
          `BSDI_OFS_SERIAL1: begin rd_kind <= 2'h0; rom_index <= 2'h2; end
          `BSDI_OFS_SERIAL2: begin rd_kind <= 2'h0; rom_index <= 2'h3; end
          `BSDI_OFS_TUNING: rd_kind <= 2'h1;
          `BSDI_OFS_BOOTSTAT: rd_kind <= 2'h2;
          default: rd_kind <= 2'h3;
        endcase
      end
      // the rom takes its index one edge after the handshake and shows
      // the word one edge later, so the answer waits out both edges
      if (rd_pending && !rd_settle)
        rd_settle <= 1'b1;
      if (rd_settle && !s_axi_rvalid)
      begin
        rd_pending <= 1'b0;
        rd_settle <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `BSDI_RESP_OKAY;
        case (rd_kind)
          2'h0: s_axi_rdata <= rom_data;
          // reserved tuning bits always read back as zero
          2'h1: s_axi_rdata <= {24'h000000, exec_speed_reduce, 7'h00};
          // status: source in bits 1:0, captured bit 2, fetch bit 3
          2'h2: s_axi_rdata <= {28'h0000000, core_fetch_enable, captured,
            boot_source};
          // unmapped: zero data with a decode error
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `BSDI_RESP_DECERR;
          end
        endcase
      end
      // the read answer stands until the master takes it
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // factory words held in a small registered rom
  // its index is registered too, so a read spends two edges in it
  bsdi_info_rom #(
    .SRAM_KB(SRAM_KB),
    .FLASH_KB(FLASH_KB),
    .SERIAL(SERIAL)
  ) u_rom (
    .aclk(aclk),
    .rd_index(rom_index),
    .rd_data(rom_data)
  );

endmodule // bsdi_boot_select
`default_nettype wire

// [logic/bsdi_info_rom.v]
// factory information words: density and 96-bit serial, registered read
`timescale 1ns/10ps
`default_nettype none
module bsdi_info_rom #(
  parameter [15:0] SRAM_KB = 16'h0008,  // sram size in kilobytes
  parameter [15:0] FLASH_KB = 16'h0020, // flash size in kilobytes
  parameter [95:0] SERIAL = 96'h0123456789abcdef00112233 // arbitrary value
)
(
  input wire aclk,           // system clock
  input wire [1:0] rd_index, // 0 density, 1..3 serial words
  output reg [31:0] rd_data  // registered read word
);

  // contents are constants, so nothing can ever write them
  always @(posedge aclk)
  begin
    case (rd_index)
      2'h0: rd_data <= {SRAM_KB, FLASH_KB};
      2'h1: rd_data <= SERIAL[31:0];
      2'h2: rd_data <= SERIAL[63:32];
      default: rd_data <= SERIAL[95:64];
    endcase
  end

endmodule // bsdi_info_rom
`default_nettype wire

// [logic/bsdi_regs.vh]
// register offsets, fields, reset values and timing counts for boot select
`ifndef BSDI_REGS_VH
`define BSDI_REGS_VH
`define BSDI_OFS_DENSITY 32'h1ffff7e0
`define BSDI_OFS_SERIAL0 32'h1ffff7e8
`define BSDI_OFS_SERIAL1 32'h1ffff7ec
`define BSDI_OFS_SERIAL2 32'h1ffff7f0
`define BSDI_OFS_TUNING 32'h4002103c
`define BSDI_OFS_BOOTSTAT 32'h40021040
`define BSDI_TUNING_RESET 32'h00000000
`define BSDI_EXEC_REDUCE_BIT 7
`define BSDI_SRAM_DEN_HI 31
`define BSDI_SRAM_DEN_LO 16
`define BSDI_FLASH_DEN_HI 15
`define BSDI_FLASH_DEN_LO 0
`define BSDI_CAPTURE_EDGE 3'h4
`define BSDI_SRC_FLASH 2'h0
`define BSDI_SRC_LOADER 2'h1
`define BSDI_SRC_SRAM 2'h2
`define BSDI_BASE_FLASH 32'h08000000
`define BSDI_BASE_SYSMEM 32'h1ffff000
`define BSDI_BASE_SRAM 32'h20000000
`define BSDI_RESP_OKAY 2'h0
`define BSDI_RESP_SLVERR 2'h2
`define BSDI_RESP_DECERR 2'h3
`endif

// [verif/bsdi_chk.sv]
// assertion checker on the boot select block ports
`timescale 1ns/10ps
`default_nettype none
module bsdi_chk (
  input wire aclk, // clock
  input wire aresetn, // sync reset, low
  input wire s_axi_bvalid, // write response valid
  input wire [1:0] boot_source, // captured source
  input wire [31:0] boot_alias_base, // aliased base
  input wire boot_alias_enable, // alias active
  input wire core_fetch_enable, // core may fetch
  input wire exec_speed_reduce // tuning bit
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_fetch_held: assert property (
    core_fetch_enable |=> core_fetch_enable)
    else $error("fetch enable dropped");
  a_fetch_late: assert property (
    $rose(aresetn) |-> !core_fetch_enable [*4])
    else $error("fetch enable too early");
  a_fetch_timely: assert property (
    $rose(aresetn) |-> ##5 core_fetch_enable)
    else $error("fetch enable not released in time");
  a_src_frozen: assert property (
    core_fetch_enable |-> $stable(boot_source) && $stable(boot_alias_base))
    else $error("boot choice moved after capture");
  a_src_legal: assert property (
    boot_source != 2'h3)
    else $error("illegal boot source code");
  a_alias_flash: assert property (
    core_fetch_enable && boot_source == 2'h0
    |-> boot_alias_enable && boot_alias_base == 32'h08000000)
    else $error("flash alias wrong");
  a_alias_loader: assert property (
    core_fetch_enable && boot_source == 2'h1
    |-> boot_alias_enable && boot_alias_base == 32'h1ffff000)
    else $error("loader alias wrong");
  a_sram_plain: assert property (
    core_fetch_enable && boot_source == 2'h2 |-> !boot_alias_enable)
    else $error("sram boot aliased");
  // the bit only moves as part of a write, whose response follows closely
  a_tune_by_write: assert property (
    $changed(exec_speed_reduce) |-> ##[0:3] s_axi_bvalid)
    else $error("tuning bit changed without write");
  cover property (core_fetch_enable && boot_source == 2'h0);
  cover property (core_fetch_enable && boot_source == 2'h2);
  cover property (core_fetch_enable && boot_source == 2'h1);
  cover property ($rose(exec_speed_reduce));
endmodule // bsdi_chk
bind bsdi_boot_select bsdi_chk u_bsdi_chk (.aclk, .aresetn, .s_axi_bvalid,
  .boot_source, .boot_alias_base, .boot_alias_enable, .core_fetch_enable,
  .exec_speed_reduce);
`default_nettype wire

// [verif/bsdi_core_model.sv]
// processor core model: where its two vector fetches land
`timescale 1ns/10ps
`default_nettype none
module bsdi_core_model (
  input wire aclk, // clock
  input wire aresetn, // sync reset, low
  input wire core_fetch_enable, // fetch allowed
  input wire boot_alias_enable, // alias active
  input wire [31:0] boot_alias_base, // aliased base
  output logic [31:0] stack_addr, // native address of stack word
  output logic [31:0] entry_addr // native address of entry word
);
  always @(posedge aclk)
  begin
    // no fetch yet: show a pattern no valid answer can match
    if (!aresetn || !core_fetch_enable)
    begin
      stack_addr <= 32'hffffffff;
      entry_addr <= 32'hffffffff;
    end
    else
    begin
      // sram boot: software moves the vector table to sram itself
      stack_addr <= boot_alias_enable ? boot_alias_base : 32'h20000000;
      entry_addr <= (boot_alias_enable ? boot_alias_base : 32'h20000000) + 4;
    end
  end
endmodule // bsdi_core_model
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the boot select block
`timescale 1ns/10ps
`default_nettype none
`include "bsdi_regs.vh"
module testbench;
  localparam [95:0] SER = 96'h5a5a0f0fc3c3a5a512345678; // arbitrary value
  logic aclk = 0, aresetn = 0, pin_lo = 0, pin_hi = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, d, r;
  logic [1:0] rsp;
  logic [3:0] wstrb = 4'hf;
  wire awready, wready, bvalid, arready, rvalid, fetch, alias_en, exec;
  wire [1:0] bresp, rresp, src;
  wire [31:0] rdata, base, stk, ent;
  integer bad_count = 0, checked = 0, seed = 32'h95e3, cyc = 0, i;
  always #20 aclk = ~aclk;
  bsdi_boot_select #(.SERIAL(SER)) u_bsdi_boot_select (.aclk(aclk),
    .aresetn(aresetn), .boot_select_low_pin(pin_lo),
    .boot_select_high_pin(pin_hi), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .boot_source(src), .boot_alias_base(base),
    .boot_alias_enable(alias_en), .core_fetch_enable(fetch),
    .exec_speed_reduce(exec));
  bsdi_core_model u_bsdi_core_model (.aclk(aclk), .aresetn(aresetn),
    .core_fetch_enable(fetch), .boot_alias_enable(alias_en),
    .boot_alias_base(base), .stack_addr(stk), .entry_addr(ent));
  // expected source from the two pins
  function automatic [1:0] exp_src(input l, input h);
    exp_src = !l ? 2'h0 : (h ? 2'h2 : 2'h1);
  endfunction
  function automatic [31:0] exp_base(input [1:0] s);
    exp_base = s == 2'h0 ? 32'h08000000 : (s == 2'h1 ? 32'h1ffff000
      : 32'h20000000);
  endfunction
  task automatic chk(input string n, input [31:0] e, input [31:0] s);
    checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // write: each channel released when its own ready is seen
  task automatic wr(input [31:0] a, input [31:0] dt, input [3:0] sb);
    @(posedge aclk);
    awaddr <= a;
    wdata <= dt;
    wstrb <= sb;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 0;
  endtask
  task automatic rd(input [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    r = rdata;
    rsp = rresp;
    rready <= 0;
  endtask
  // reset with pins set, then watch capture and fetch release
  task automatic boot(input l, input h);
    @(posedge aclk);
    pin_lo <= l;
    pin_hi <= h;
    aresetn <= 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    #1;
    chk("source early", 2'h0, src);
    @(posedge aclk);
    #1;
    chk("fetch held", 0, fetch);
    chk("source", exp_src(l, h), src);
    @(posedge aclk);
    #1;
    chk("fetch free", 1, fetch);
    chk("alias base", exp_base(exp_src(l, h)), base);
    chk("alias on", exp_src(l, h) != 2'h2, alias_en);
    @(posedge aclk);
    pin_lo <= $random(seed);
    pin_hi <= $random(seed);
    repeat (4) @(posedge aclk);
    #1;
    chk("source kept", exp_src(l, h), src);
    chk("stack fetch", exp_base(exp_src(l, h)), stk);
    chk("entry fetch", exp_base(exp_src(l, h)) + 4, ent);
  endtask
  initial
  begin
    for (i = 0; i < 4; i++) boot(i[0], i[1]);
    rd(`BSDI_OFS_BOOTSTAT);
    chk("status", {28'h0, 1'b1, 1'b1, exp_src(1, 1)}, r);
    rd(`BSDI_OFS_DENSITY);
    chk("density", {16'h0008, 16'h0020}, r);
    for (i = 0; i < 3; i++)
    begin
      rd(`BSDI_OFS_SERIAL0 + 4 * i);
      chk("serial", SER[32 * i +: 32], r);
    end
    wr(`BSDI_OFS_DENSITY, $random(seed), 4'hf);
    chk("density wresp", `BSDI_RESP_SLVERR, rsp);
    wr(`BSDI_OFS_SERIAL1, $random(seed), 4'hf);
    chk("serial wresp", `BSDI_RESP_SLVERR, rsp);
    rd(`BSDI_OFS_SERIAL1);
    chk("serial kept", SER[63:32], r);
    rd(`BSDI_OFS_TUNING);
    chk("tuning reset", 32'h0, r);
    for (i = 0; i < 5; i++)
    begin
      // read-modify-write of bit 7 alone, as software must
      rd(`BSDI_OFS_TUNING);
      d = r;
      d[7] = i == 0 ? 1'b1 : (i == 1 ? 1'b0 : $random(seed));
      wr(`BSDI_OFS_TUNING, d, 4'hf);
      chk("tuning wresp", `BSDI_RESP_OKAY, rsp);
      rd(`BSDI_OFS_TUNING);
      chk("tuning read", {24'h0, d[7], 7'h0}, r);
      chk("reduce pin", d[7], exec);
    end
    // a write without byte 0 must leave the bit as it was
    rd(`BSDI_OFS_TUNING);
    d = r;
    d[7] = !r[7];
    wr(`BSDI_OFS_TUNING, d, 4'he);
    chk("masked write", r[7], exec);
    rd(32'h00001000);
    chk("unmapped resp", `BSDI_RESP_DECERR, rsp);
    chk("unmapped data", 32'h0, r);
    wr(32'h00001000, $random(seed), 4'hf);
    chk("unmapped wresp", `BSDI_RESP_DECERR, rsp);
    complete_run;
  end
  // hang guard: a run this short never needs 3000 cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
endmodule // testbench
`default_nettype wire
